// [icb_sequencer.sv]
// Overview of operation
// - add address-mode cost where table marks it
// - long add/sub/and/or register direct: 8 total
// - exclusive_or to data register: register sources only
// - shifts: 6/8 plus 2n, memory 9
// - multiplies 70 clocks plus address-mode cost, one read
// - cond_branch taken 10, not taken 8/12
// - short jump 10, subroutine_branch 20 (2/2)
// - loop branch 12 true, 10 taken, 14 expired
// - bounds_check 43 trapping, 8 otherwise
// - set_on_condition 4/6 register, 9 memory
// - test_and_set_byte 4 register, 11 memory
// - long register bit ops by bit number source
// - byte memory bit ops 9/13, probe 4/8
// - immediate logic: status 20, register 8/16
// - quick load 4, quick add/sub 4/8/9/14
// - long compare_immediate 14 register, 12 memory
// - operand_test 4 clocks, one read, no write
// - zeroing/negate/complement 4/6 register, 9/14 memory
// - counts cover operation, store and prefetch
// - every count paired with read/write counts
`timescale 1ns/1ps
`default_nettype none
`include "icb_defs.svh"

module icb_sequencer
    import icb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire icb_req_t    req,
    output var  logic        ready,
    output var  logic        busy,
    output var  logic        done,
    output var  logic        reject,
    output var  icb_budget_t budget
);

    icb_regs_t   s_q;      // registered state
    icb_regs_t   s_d;      // next state
    icb_cost_t   cost;     // table figure for the offered request
    icb_budget_t total;    // table figure plus address-mode cost
    logic        accept;   // request taken this cycle

    // builds one legal table entry
    function automatic icb_cost_t mk(
        input logic [8:0] c,
        input logic [3:0] r,
        input logic [3:0] w,
        input logic       ea
    );
        mk = '{legal: 1'b1, add_ea: ea, budget: '{clocks: c, reads: r, writes: w}};
    endfunction

    // cycle budget table; a zero result marks an illegal combination
    function automatic icb_cost_t lookup(input icb_req_t q);
        logic lg;
        logic an;
        logic mem;
        logic sr;
        logic flow;
        lg   = (q.size == ICB_SZ_LONG);
        an   = (q.form == ICB_FORM_AREG);
        mem  = (q.form == ICB_FORM_MEM);
        sr   = (q.form == ICB_FORM_STATUS);
        flow = (q.op >= ICB_OP_CBRANCH);
        lookup = '0;
        // figures include operation, result store and next-word prefetch
        case (q.op)
            ICB_OP_ADD, ICB_OP_SUB, ICB_OP_AND, ICB_OP_OR: begin
                if (mem) begin
                    lookup = lg ? mk(`ICB_CLK_14, `ICB_RW_1, `ICB_RW_2, 1'b1)
                                : mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end else if (lg) begin
                    // register direct source: flat total, no address cost
                    lookup = q.src_reg_direct ? mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                              : mk(`ICB_CLK_6, `ICB_RW_1, `ICB_RW_0, 1'b1);
                end else begin
                    lookup = an ? mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b1)
                                : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b1);
                end
            end
            ICB_OP_CMP: begin
                // compare has no memory destination
                if (!mem) begin
                    lookup = (an || lg) ? mk(`ICB_CLK_6, `ICB_RW_1, `ICB_RW_0, 1'b1)
                                        : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b1);
                end
            end
            ICB_OP_XOR: begin
                if (mem) begin
                    lookup = lg ? mk(`ICB_CLK_14, `ICB_RW_1, `ICB_RW_2, 1'b1)
                                : mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end else if (q.src_dreg) begin
                    // data register destination takes data register sources only
                    lookup = lg ? mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_SDIV: lookup = mk(`ICB_CLK_158, `ICB_RW_1, `ICB_RW_0, 1'b1);
            ICB_OP_UDIV: lookup = mk(`ICB_CLK_140, `ICB_RW_1, `ICB_RW_0, 1'b1);
            ICB_OP_SMUL, ICB_OP_UMUL: begin
                lookup = mk(`ICB_CLK_70, `ICB_RW_1, `ICB_RW_0, 1'b1);
            end
            ICB_OP_IMM_LOGIC, ICB_OP_IMM_ARITH: begin
                if (sr) begin
                    // status word target, byte or word only
                    if (!lg) begin
                        lookup = mk(`ICB_CLK_20, `ICB_RW_3, `ICB_RW_0, 1'b0);
                    end
                end else if (mem) begin
                    lookup = lg ? mk(`ICB_CLK_22, `ICB_RW_3, `ICB_RW_2, 1'b1)
                                : mk(`ICB_CLK_13, `ICB_RW_2, `ICB_RW_1, 1'b1);
                end else begin
                    lookup = lg ? mk(`ICB_CLK_16, `ICB_RW_3, `ICB_RW_0, 1'b0)
                                : mk(`ICB_CLK_8, `ICB_RW_2, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_COMPARE_IMMEDIATE: begin
                // compare never writes
                if (lg) begin
                    lookup = mem ? mk(`ICB_CLK_12, `ICB_RW_3, `ICB_RW_0, 1'b1)
                                 : mk(`ICB_CLK_14, `ICB_RW_3, `ICB_RW_0, 1'b0);
                end else begin
                    lookup = mk(`ICB_CLK_8, `ICB_RW_2, `ICB_RW_0, mem);
                end
            end
            ICB_OP_QLOAD: begin
                if (!mem) begin
                    lookup = mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_QADDSUB: begin
                if (mem) begin
                    lookup = lg ? mk(`ICB_CLK_14, `ICB_RW_1, `ICB_RW_2, 1'b1)
                                : mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end else begin
                    lookup = lg ? mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_ZERO_NEG: begin
                if (mem) begin
                    lookup = lg ? mk(`ICB_CLK_14, `ICB_RW_1, `ICB_RW_2, 1'b1)
                                : mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end else begin
                    lookup = lg ? mk(`ICB_CLK_6, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_SETCOND: begin
                if (mem) begin
                    lookup = mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end else begin
                    lookup = q.cond_true ? mk(`ICB_CLK_6, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                         : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_TAS: begin
                lookup = mem ? mk(`ICB_CLK_11, `ICB_RW_1, `ICB_RW_1, 1'b1)
                             : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
            end
            ICB_OP_TEST: begin
                // no write cycle in any form; long memory adds address cost
                lookup = mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, mem && lg);
            end
            ICB_OP_SHIFT: begin
                if (!mem) begin
                    // two clocks per shifted position
                    lookup = mk((lg ? `ICB_CLK_8 : `ICB_CLK_6) + {2'b00, q.shift_n, 1'b0},
                                `ICB_RW_1, `ICB_RW_0, 1'b0);
                end else if (!lg) begin
                    lookup = mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1);
                end
            end
            ICB_OP_BIT_MOD, ICB_OP_BIT_CLR, ICB_OP_BIT_PROBE: begin
                if (mem) begin
                    // byte in memory; probe never writes
                    if (q.op == ICB_OP_BIT_PROBE) begin
                        lookup = q.bit_dynamic ? mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b1)
                                               : mk(`ICB_CLK_8, `ICB_RW_2, `ICB_RW_0, 1'b1);
                    end else begin
                        lookup = q.bit_dynamic ? mk(`ICB_CLK_9, `ICB_RW_1, `ICB_RW_1, 1'b1)
                                               : mk(`ICB_CLK_13, `ICB_RW_2, `ICB_RW_1, 1'b1);
                    end
                end else if (q.op == ICB_OP_BIT_PROBE) begin
                    lookup = q.bit_dynamic ? mk(`ICB_CLK_6, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                           : mk(`ICB_CLK_10, `ICB_RW_2, `ICB_RW_0, 1'b0);
                end else if (q.op == ICB_OP_BIT_CLR) begin
                    lookup = q.bit_dynamic ? mk(`ICB_CLK_10, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                           : mk(`ICB_CLK_14, `ICB_RW_2, `ICB_RW_0, 1'b0);
                end else begin
                    lookup = q.bit_dynamic ? mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b0)
                                           : mk(`ICB_CLK_12, `ICB_RW_2, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_CBRANCH: begin
                if (q.taken) begin
                    lookup = mk(`ICB_CLK_10, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end else begin
                    lookup = q.disp_word ? mk(`ICB_CLK_12, `ICB_RW_2, `ICB_RW_0, 1'b0)
                                         : mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_UBRANCH: lookup = mk(`ICB_CLK_10, `ICB_RW_1, `ICB_RW_0, 1'b0);
            ICB_OP_SUBBR:   lookup = mk(`ICB_CLK_20, `ICB_RW_2, `ICB_RW_2, 1'b0);
            ICB_OP_LOOPBR: begin
                // condition true, else counter live (taken) or expired
                if (q.cond_true) begin
                    lookup = mk(`ICB_CLK_12, `ICB_RW_2, `ICB_RW_0, 1'b0);
                end else begin
                    lookup = q.taken ? mk(`ICB_CLK_10, `ICB_RW_2, `ICB_RW_0, 1'b0)
                                     : mk(`ICB_CLK_14, `ICB_RW_3, `ICB_RW_0, 1'b0);
                end
            end
            ICB_OP_BOUNDS: begin
                lookup = q.taken ? mk(`ICB_CLK_43, `ICB_RW_5, `ICB_RW_3, 1'b1)
                                 : mk(`ICB_CLK_8, `ICB_RW_1, `ICB_RW_0, 1'b1);
            end
            ICB_OP_TRAP: lookup = mk(`ICB_CLK_37, `ICB_RW_4, `ICB_RW_3, 1'b0);
            ICB_OP_OVTRAP: begin
                lookup = q.taken ? mk(`ICB_CLK_37, `ICB_RW_5, `ICB_RW_3, 1'b0)
                                 : mk(`ICB_CLK_4, `ICB_RW_1, `ICB_RW_0, 1'b0);
            end
            default: lookup = '0;
        endcase
        // address register and status word targets only where listed
        if (!flow && an && !(q.op inside {ICB_OP_ADD, ICB_OP_SUB, ICB_OP_CMP})) begin
            lookup = '0;
        end
        if (!flow && sr && !(q.op == ICB_OP_IMM_LOGIC)) begin
            lookup = '0;
        end
        if (q.size == 2'b11) begin
            lookup = '0;
        end
    endfunction

    // table figure for the request on the port
    assign cost = lookup(req);

    // address-mode cost added only where marked
    assign total = cost.add_ea ?
        icb_budget_t'{clocks: cost.budget.clocks + {4'h0, req.ea_clocks},
          reads:  cost.budget.reads + {1'b0, req.ea_reads},
          writes: cost.budget.writes + {1'b0, req.ea_writes}} : cost.budget;

    assign accept = req_valid && s_q.ready && cost.legal;

    // next state: load the budget, then count it down
    always_comb begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.reject = 1'b0;
        unique case (s_q.st)
            ICB_IDLE: begin
                if (req_valid && cost.legal) begin
                    // clocks and bus counts travel together
                    s_d.budget = total;
                    s_d.remain = total.clocks - 9'h001;
                    s_d.busy   = 1'b1;
                    s_d.ready  = 1'b0;
                    s_d.st     = ICB_RUN;
                end else if (req_valid) begin
                    // illegal combination: refused, nothing starts
                    s_d.reject = 1'b1;
                end
            end
            ICB_RUN: begin
                // zero wait states assumed, so the count is exact
                if (s_q.remain == 9'h000) begin
                    s_d.st    = ICB_IDLE;
                    s_d.busy  = 1'b0;
                    s_d.ready = 1'b1;
                    s_d.done  = 1'b1;
                end else begin
                    s_d.remain = s_q.remain - 9'h001;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '{st: ICB_IDLE, remain: '0, budget: '0, ready: `ICB_RST_READY,
                     busy: 1'b0, done: 1'b0, reject: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign ready  = s_q.ready;
    assign busy   = s_q.busy;
    assign done   = s_q.done;
    assign reject = s_q.reject;
    assign budget = s_q.budget;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_busy_min_len: assert property ($rose(s_q.busy) |-> s_q.busy [*4])
        else $error("busy shorter than four clocks");
    a_busy_load_count: assert property ($rose(s_q.busy) |->
        s_q.remain == s_q.budget.clocks - 9'h001)
        else $error("countdown not loaded from budget");
    a_busy_end_done: assert property ($fell(s_q.busy) && !$past(rst) |->
        s_q.done && s_q.ready)
        else $error("busy ended without done");
    a_xor_src_reject: assert property (req_valid && s_q.ready && req.op == ICB_OP_XOR &&
        req.form == ICB_FORM_DREG && !req.src_dreg |=> s_q.reject && !s_q.busy)
        else $error("non-register exclusive_or source accepted");
    a_long_reg_eight: assert property (accept && req.size == ICB_SZ_LONG &&
        req.op inside {ICB_OP_ADD, ICB_OP_SUB} && req.form == ICB_FORM_DREG &&
        req.src_reg_direct |=> s_q.budget.clocks == `ICB_CLK_8)
        else $error("long register direct total not eight");
    a_shift_reg_count: assert property (accept && req.op == ICB_OP_SHIFT &&
        req.form == ICB_FORM_DREG && req.size != ICB_SZ_LONG |=>
        s_q.budget.clocks == `ICB_CLK_6 + {2'b00, $past(req.shift_n), 1'b0})
        else $error("shift clock count wrong");
    a_sdiv_budget: assert property (accept && req.op == ICB_OP_SDIV |=>
        s_q.budget.clocks == `ICB_CLK_158 + {4'h0, $past(req.ea_clocks)} &&
        s_q.budget.reads == `ICB_RW_1 + {1'b0, $past(req.ea_reads)})
        else $error("signed divide budget wrong");
    a_mul_budget: assert property (accept && req.op inside {ICB_OP_SMUL, ICB_OP_UMUL} |=>
        s_q.budget.clocks == `ICB_CLK_70 + {4'h0, $past(req.ea_clocks)})
        else $error("multiply budget wrong");
    a_branch_word_miss: assert property (accept && req.op == ICB_OP_CBRANCH &&
        !req.taken && req.disp_word |=> s_q.budget.clocks == `ICB_CLK_12 &&
        s_q.budget.reads == `ICB_RW_2)
        else $error("untaken word branch budget wrong");
    a_subbr_budget: assert property (accept && req.op == ICB_OP_SUBBR |=>
        s_q.budget == '{clocks: `ICB_CLK_20, reads: `ICB_RW_2, writes: `ICB_RW_2})
        else $error("subroutine branch budget wrong");
    a_loop_expired: assert property (accept && req.op == ICB_OP_LOOPBR &&
        !req.cond_true && !req.taken |=> s_q.budget.clocks == `ICB_CLK_14 &&
        s_q.budget.reads == `ICB_RW_3)
        else $error("expired loop budget wrong");
    a_bounds_trap: assert property (accept && req.op == ICB_OP_BOUNDS && req.taken |=>
        s_q.budget.writes == `ICB_RW_3 + {1'b0, $past(req.ea_writes)})
        else $error("bounds trap writes wrong");
    a_test_no_write: assert property (accept && req.op == ICB_OP_TEST |=>
        s_q.budget.clocks == `ICB_CLK_4 + ($past(req.form == ICB_FORM_MEM &&
        req.size == ICB_SZ_LONG) ? {4'h0, $past(req.ea_clocks)} : 9'h000) &&
        s_q.budget.writes == `ICB_RW_0)
        else $error("operand test clock count wrong");

endmodule
`default_nettype wire

// [icb_defs.svh]
`ifndef ICB_DEFS_SVH
`define ICB_DEFS_SVH

// execution clock figures, each one the table cost before any address-mode or shift-count clocks, with no wait states
`define ICB_CLK_4   9'h004
`define ICB_CLK_6   9'h006
`define ICB_CLK_8   9'h008
`define ICB_CLK_9   9'h009
`define ICB_CLK_10  9'h00a
`define ICB_CLK_11  9'h00b
`define ICB_CLK_12  9'h00c
`define ICB_CLK_13  9'h00d
`define ICB_CLK_14  9'h00e
`define ICB_CLK_16  9'h010
`define ICB_CLK_20  9'h014
`define ICB_CLK_22  9'h016
`define ICB_CLK_37  9'h025
`define ICB_CLK_43  9'h02b
`define ICB_CLK_70  9'h046
`define ICB_CLK_140 9'h08c
`define ICB_CLK_158 9'h09e

// bus read or write cycle counts
`define ICB_RW_0    4'h0
`define ICB_RW_1    4'h1
`define ICB_RW_2    4'h2
`define ICB_RW_3    4'h3
`define ICB_RW_4    4'h4
`define ICB_RW_5    4'h5

// reset value of the ready flag
`define ICB_RST_READY 1'b1

`endif

// [icb_pkg.sv]
`default_nettype none
package icb_pkg;

    // instruction classes that carry a cycle budget
    typedef enum logic [4:0] {
        ICB_OP_ADD, ICB_OP_SUB, ICB_OP_AND, ICB_OP_OR, ICB_OP_CMP, ICB_OP_XOR,
        ICB_OP_SDIV, ICB_OP_UDIV, ICB_OP_SMUL, ICB_OP_UMUL,
        ICB_OP_IMM_LOGIC, ICB_OP_IMM_ARITH, ICB_OP_COMPARE_IMMEDIATE, ICB_OP_QLOAD, ICB_OP_QADDSUB,
        ICB_OP_ZERO_NEG, ICB_OP_SETCOND, ICB_OP_TAS, ICB_OP_TEST, ICB_OP_SHIFT,
        ICB_OP_BIT_MOD, ICB_OP_BIT_CLR, ICB_OP_BIT_PROBE,
        ICB_OP_CBRANCH, ICB_OP_UBRANCH, ICB_OP_SUBBR, ICB_OP_LOOPBR,
        ICB_OP_BOUNDS, ICB_OP_TRAP, ICB_OP_OVTRAP
    } icb_op_t;

    // operand size; code 3 is illegal
    typedef enum logic [1:0] {ICB_SZ_BYTE, ICB_SZ_WORD, ICB_SZ_LONG} icb_size_t;

    // destination form: data register, address register, memory, status word
    typedef enum logic [1:0] {
        ICB_FORM_DREG, ICB_FORM_AREG, ICB_FORM_MEM, ICB_FORM_STATUS
    } icb_form_t;

    // one instruction request with its effective address cost
    typedef struct packed {
        icb_op_t    op;
        icb_size_t  size;
        icb_form_t  form;
        logic       src_dreg;
        logic       src_reg_direct;
        logic       cond_true;
        logic       taken;
        logic       disp_word;
        logic       bit_dynamic;
        logic [5:0] shift_n;
        logic [4:0] ea_clocks;
        logic [2:0] ea_reads;
        logic [2:0] ea_writes;
    } icb_req_t;

    // clock count paired with bus read and write counts
    typedef struct packed {
        logic [8:0] clocks;
        logic [3:0] reads;
        logic [3:0] writes;
    } icb_budget_t;

    // table lookup result
    typedef struct packed {
        logic        legal;
        logic        add_ea;
        icb_budget_t budget;
    } icb_cost_t;

    // sequencer states, gray coded
    typedef enum logic [1:0] {ICB_IDLE = 2'b00, ICB_RUN = 2'b01} icb_state_t;

    // complete sequencer state
    typedef struct packed {
        icb_state_t  st;
        logic [8:0]  remain;
        icb_budget_t budget;
        logic        ready;
        logic        busy;
        logic        done;
        logic        reject;
    } icb_regs_t;

endpackage
`default_nettype wire

// [icb_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module icb_bus_model
    import icb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        busy,
    input  wire icb_budget_t budget,
    output var  logic [3:0]  rd_served,
    output var  logic [3:0]  wr_served
);
    logic       busy_q; // busy one cycle ago
    logic [8:0] slot_q; // bus slots used so far by this instruction
    logic [8:0] extra;  // slots left once all reads are done
    // one transfer each busy cycle and never a wait state
    always_ff @(posedge core_clk) begin
        busy_q <= rst ? 1'b0 : busy;
        if (rst)
            slot_q <= 9'h000;
        else if (busy && !busy_q)
            slot_q <= 9'h001;
        else if (busy)
            slot_q <= slot_q + 9'h001;
    end
    // reads are served first, then writes, as the budget pairs them
    always_comb begin
        extra = slot_q - {5'h0, budget.reads};
        rd_served = (slot_q > {5'h0, budget.reads}) ? budget.reads : slot_q[3:0];
        if (slot_q <= {5'h0, budget.reads})
            wr_served = 4'h0;
        else
            wr_served = (extra > {5'h0, budget.writes}) ? budget.writes : extra[3:0];
    end
endmodule
`default_nettype wire

// [icb_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module icb_sequencer_tb
    import icb_pkg::*;
;
    typedef struct packed {icb_req_t rq; logic [16:0] ex;} icb_row_t; // request, expected
    localparam icb_size_t sb = ICB_SZ_BYTE, sw = ICB_SZ_WORD, sl = ICB_SZ_LONG;
    localparam icb_form_t fd = ICB_FORM_DREG, fa = ICB_FORM_AREG;
    localparam icb_form_t fm = ICB_FORM_MEM, fs = ICB_FORM_STATUS;
    logic        core_clk, rst, req_valid, ready, busy, done, reject;
    icb_req_t    req;        // request driven into the sequencer
    icb_budget_t budget;     // budget reported back
    logic [3:0]  rd_served, wr_served;
    int          n_fail, comparisons;
    icb_row_t    rows[$];    // ordinary cases
    icb_req_t    bad;        // exclusive_or request with a non-register source
    icb_sequencer u_icb_sequencer (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req(req), .ready(ready), .busy(busy), .done(done), .reject(reject), .budget(budget));
    icb_bus_model u_icb_bus_model (.core_clk(core_clk), .rst(rst), .busy(busy),
        .budget(budget), .rd_served(rd_served), .wr_served(wr_served));
    // free running clock, 5 ns period
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // flag bits: src_dreg, src_reg_direct, cond_true, taken, disp_word, bit_dynamic
    task automatic add(input icb_op_t o, input icb_size_t s, input icb_form_t f,
        input logic [5:0] fl, input logic [5:0] n, input logic [4:0] e,
        input logic [8:0] c, input logic [3:0] r, input logic [3:0] w);
        icb_row_t x;
        x = '0;
        x.rq.op = o;
        x.rq.size = s;
        x.rq.form = f;
        {x.rq.src_dreg, x.rq.src_reg_direct, x.rq.cond_true, x.rq.taken, x.rq.disp_word,
         x.rq.bit_dynamic} = fl;
        x.rq.shift_n = n;
        x.rq.ea_clocks = e;
        x.rq.ea_reads = {2'b00, e != 5'h0};
        x.ex = {c, r, w};
        rows.push_back(x);
    endtask
    // compare and count, report at once on a mismatch
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // offer one request, then follow it until done
    task automatic run(input icb_row_t x);
        int k;
        k = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= x.rq;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        cmp(budget, x.ex);
        while (busy === 1'b1 && k < 400) begin
            k++;
            @(negedge core_clk);
        end
        cmp(k[16:0], {8'h00, x.ex[16:8]});
        cmp({15'h0000, ready, done}, 17'h0003);
        cmp({9'h000, rd_served, wr_served}, {9'h000, x.ex[7:0]});
    endtask
    // print counts and verdict, then stop
    task automatic tally_and_finish;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (6000) @(posedge core_clk);
        n_fail++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        add(ICB_OP_TRAP, sw, fd, 6'h00, 0, 0, 37, 4, 3);
        add(ICB_OP_OVTRAP, sw, fd, 6'h04, 0, 0, 37, 5, 3);
        add(ICB_OP_OVTRAP, sw, fd, 6'h00, 0, 0, 4, 1, 0);
        add(ICB_OP_CBRANCH, sw, fd, 6'h06, 0, 0, 10, 1, 0);
        add(ICB_OP_CBRANCH, sw, fd, 6'h00, 0, 0, 8, 1, 0);
        add(ICB_OP_CBRANCH, sw, fd, 6'h02, 0, 0, 12, 2, 0);
        add(ICB_OP_UBRANCH, sw, fd, 6'h02, 0, 0, 10, 1, 0);
        add(ICB_OP_SUBBR, sw, fd, 6'h00, 0, 0, 20, 2, 2);
        add(ICB_OP_LOOPBR, sw, fd, 6'h08, 0, 0, 12, 2, 0);
        add(ICB_OP_LOOPBR, sw, fd, 6'h04, 0, 0, 10, 2, 0);
        add(ICB_OP_LOOPBR, sw, fd, 6'h00, 0, 0, 14, 3, 0);
        add(ICB_OP_XOR, sb, fd, 6'h20, 0, 0, 4, 1, 0);
        add(ICB_OP_XOR, sl, fd, 6'h20, 0, 0, 8, 1, 0);
        add(ICB_OP_ADD, sl, fa, 6'h10, 0, 4, 8, 1, 0);
        add(ICB_OP_AND, sl, fd, 6'h00, 0, 4, 10, 2, 0);
        add(ICB_OP_SUB, sw, fd, 6'h00, 0, 4, 8, 2, 0);
        add(ICB_OP_SHIFT, sw, fd, 6'h00, 3, 0, 12, 1, 0);
        add(ICB_OP_SHIFT, sl, fd, 6'h00, 5, 0, 18, 1, 0);
        add(ICB_OP_SHIFT, sw, fm, 6'h00, 0, 0, 9, 1, 1);
        add(ICB_OP_SDIV, sw, fd, 6'h00, 0, 0, 158, 1, 0);
        add(ICB_OP_UDIV, sw, fd, 6'h00, 0, 0, 140, 1, 0);
        add(ICB_OP_SMUL, sw, fd, 6'h00, 0, 0, 70, 1, 0);
        add(ICB_OP_BOUNDS, sw, fd, 6'h04, 0, 0, 43, 5, 3);
        add(ICB_OP_BOUNDS, sw, fd, 6'h00, 0, 0, 8, 1, 0);
        add(ICB_OP_SETCOND, sb, fd, 6'h08, 0, 0, 6, 1, 0);
        add(ICB_OP_SETCOND, sb, fm, 6'h00, 0, 0, 9, 1, 1);
        add(ICB_OP_TAS, sb, fm, 6'h00, 0, 0, 11, 1, 1);
        add(ICB_OP_BIT_CLR, sl, fd, 6'h00, 0, 0, 14, 2, 0);
        add(ICB_OP_BIT_MOD, sb, fm, 6'h01, 0, 0, 9, 1, 1);
        add(ICB_OP_BIT_PROBE, sb, fm, 6'h00, 0, 0, 8, 2, 0);
        add(ICB_OP_IMM_LOGIC, sw, fs, 6'h00, 0, 0, 20, 3, 0);
        add(ICB_OP_QADDSUB, sl, fm, 6'h00, 0, 0, 14, 1, 2);
        add(ICB_OP_COMPARE_IMMEDIATE, sl, fm, 6'h00, 0, 0, 12, 3, 0);
        add(ICB_OP_TEST, sl, fd, 6'h00, 0, 0, 4, 1, 0);
        add(ICB_OP_ZERO_NEG, sl, fm, 6'h00, 0, 0, 14, 1, 2);
        add(ICB_OP_SUB, sl, fd, 6'h10, 0, 4, 8, 1, 0);
        add(ICB_OP_UMUL, sw, fd, 6'h00, 0, 2, 72, 2, 0);
        add(ICB_OP_QLOAD, sl, fd, 6'h00, 0, 0, 4, 1, 0);
        add(ICB_OP_OR, sw, fm, 6'h00, 0, 4, 13, 2, 1);
        add(ICB_OP_CMP, sl, fa, 6'h00, 0, 0, 6, 1, 0);
        add(ICB_OP_IMM_ARITH, sl, fd, 6'h00, 0, 0, 16, 3, 0);
        add(ICB_OP_BIT_PROBE, sl, fd, 6'h01, 0, 0, 6, 1, 0);
        add(ICB_OP_TAS, sb, fd, 6'h00, 0, 0, 4, 1, 0);
        add(ICB_OP_SETCOND, sb, fd, 6'h00, 0, 0, 4, 1, 0);
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        cmp({13'h0000, ready, busy, done, reject}, 17'h0008);
        cmp(budget, 17'h0_0000);
        foreach (rows[i]) run(rows[i]);
        // illegal source for exclusive_or gives a reject pulse only
        @(posedge core_clk);
        req_valid <= 1'b1;
        bad = rows[11].rq;
        bad.src_dreg = 1'b0;
        req <= bad;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        cmp({14'h0000, reject, busy, ready}, 17'h0005);
        // a request offered while busy is ignored
        run(rows[0]);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= rows[33].rq;
        @(posedge core_clk);
        req <= rows[7].rq;
        repeat (2) @(posedge core_clk);
        req_valid <= 1'b0;
        repeat (6) @(negedge core_clk);
        cmp({16'h0000, busy}, 17'h0000);
        cmp(budget, rows[33].ex);
        // reset in mid-run clears the budget, then work resumes
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= rows[19].rq;
        @(posedge core_clk);
        req_valid <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        cmp({15'h0000, ready, busy}, 17'h0002);
        cmp(budget, 17'h0_0000);
        run(rows[7]);
        tally_and_finish;
    end
endmodule
`default_nettype wire
